// ---- wlmpr_defs.svh ----
// Purpose: constants for write leveling and register readout logic
// Assumes: mode register bits arrive as a 16-bit address word
// Notes: all positions are bit indices into the command address word
`ifndef WLMPR_DEFS_SVH
`define WLMPR_DEFS_SVH
`define MR1_LEVEL_BIT 7
`define MR1_QOFF_BIT 12
`define MR3_MPR_BIT 2
`define MR3_LOC_LSB 0
`define MR0_BL_LSB 0
`define COL_BC_BIT 12
`define COL_NIBBLE_BIT 2
`define MPR_PATTERN 8'haa
`define MR1_UPD_MASK 16'h1a66
`define MR_ADDR_RESET 16'h0000
`define TWLO_NS 9
`define TWLO_CYC ((`TWLO_NS * 200 + 999) / 1000)
`endif

// ---- wlmpr_pkg.sv ----
// Purpose: shared types for write leveling and register readout logic
// Assumes: nothing beyond the defs header
// Notes: burst state for the readout serializer
package wlmpr_pkg;
   typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} rd_state_type;
endpackage : wlmpr_pkg

// ---- wlmpr_if.sv ----
// Purpose: carries leveling feedback between top and feedback stage
// Assumes: one clock domain
// Notes: top drives sample and control, stage returns the dq value
`timescale 1ns/1ps
`default_nettype none
interface wlmpr_if;
   logic level_en; // leveling mode active
   logic sample_stb; // one-cycle pulse on strobe rise
   logic ck_level; // clock level caught by the strobe
   logic all_bits; // feedback on every bit
   logic fb_valid; // feedback has been produced once
   logic [7:0] fb_dq; // feedback byte
   modport top (output level_en, sample_stb, ck_level, all_bits, input fb_valid, fb_dq);
   modport stage (input level_en, sample_stb, ck_level, all_bits, output fb_valid, fb_dq);
endinterface : wlmpr_if
`default_nettype wire

// ---- wl_feedback.sv ----
// Purpose: delayed leveling feedback onto the data byte
// Assumes: sample_stb pulses once per rising strobe edge
// Notes: twlo is modelled as a fixed cycle delay
`timescale 1ns/1ps
`default_nettype none
`include "wlmpr_defs.svh"
module wl_feedback #(
   parameter int DELAY = `TWLO_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // link to top
   wlmpr_if.stage lnk
);
   logic [DELAY-1:0] pipe_ff; // sample pulse delay line
   logic [DELAY-1:0] lvl_ff; // sampled level delay line
   logic [7:0] fb_dq_ff; // feedback byte
   logic fb_valid_ff; // first sample done

   // delay line for the twlo latency
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         pipe_ff <= '0;
         lvl_ff <= '0;
      end
      else
      begin
         pipe_ff <= {pipe_ff[DELAY-2:0], lnk.sample_stb};
         lvl_ff <= {lvl_ff[DELAY-2:0], lnk.ck_level};
      end
   end

   // feedback byte; idle bits held low, or copy the sample when all_bits is set, once the first sample lands
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i || !lnk.level_en)
      begin
         fb_dq_ff <= 8'h00;
         fb_valid_ff <= 1'b0;
      end
      else if (pipe_ff[DELAY-1])
      begin
         fb_valid_ff <= 1'b1;
         // high sample gives one, low sample gives zero
         fb_dq_ff <= lnk.all_bits ? {8{lvl_ff[DELAY-1]}} : {7'h00, lvl_ff[DELAY-1]};
      end
   end

   assign lnk.fb_dq = fb_dq_ff;
   assign lnk.fb_valid = fb_valid_ff;

   a_fb_level: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      pipe_ff[DELAY-1] && lnk.level_en |=> fb_dq_ff[0] == $past(lvl_ff[DELAY-1]))
      else $error("feedback bit does not match sampled clock");
   a_fb_idle_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      fb_valid_ff && !lnk.all_bits && $stable(lnk.all_bits) |-> fb_dq_ff[7:1] == 7'h00)
      else $error("non-prime feedback bits not low");
endmodule : wl_feedback
`default_nettype wire

// ---- wlmpr_top.sv ----
// Purpose: write leveling feedback and register readout inside the memory device
// Assumes: decoded commands arrive on mclk_i; strobe and clock level are pins
// Notes: read latency is a port value counted in cycles of mclk_i
`timescale 1ns/1ps
`default_nettype none
`include "wlmpr_defs.svh"

// Behaviour
// - MR1 A7 enters and leaves leveling
// - leveling ODT terminates strobes only
// - exit write may update listed MR1 bits
// - strobe rise samples clock, delayed feedback
// - prime bit feedback, others held low or copied
// - MR3 A2 redirects reads to register
// - autoprecharge ignored during register reads
// - MR3 A[1:0] selects readout location
// - serial on bit zero, others copy/zero
// - chopped reads pick nibble by A2
// - A12 chops on fly; others ignored
// - burst position zero is LSB
// - location 00 gives alternating pattern
module wlmpr_top #(
   parameter int RL_W = 5 // width of read latency count
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // decoded commands
   input wire logic mrs_i, // mode register write pulse
   input wire logic [2:0] mr_sel_i, // target mode register
   input wire logic [15:0] addr_i, // address word
   input wire logic rd_i, // read pulse
   input wire logic rd_ap_i, // read with autoprecharge
   // pins
   input wire logic odt_i, // termination request pin
   input wire logic dqs_i, // data strobe pin
   input wire logic ck_i, // clock level as seen at strobe edge
   // configuration
   input wire logic [RL_W-1:0] rl_i, // read latency in cycles
   input wire logic fb_all_bits_i, // feedback on all bits
   input wire logic mpr_copy_i, // upper bits copy bit zero
   // outputs
   output logic [7:0] dq_o, // data byte
   output logic dq_oe_b_o, // low while driving data
   output logic rtt_dqs_o, // strobe termination on
   output logic rtt_dq_o, // data termination on
   output logic level_mode_o, // leveling active
   output logic mpr_mode_o, // register readout active
   output logic [15:0] mr1_o, // current MR1 image
   output logic precharge_o // autoprecharge request to array
);
   logic [15:0] mr0_ff, mr1_ff, mr3_ff; // mode register images
   logic [2:0] dqs_sync_ff, ck_sync_ff, odt_sync_ff; // pin synchronisers plus history
   logic rtt_dqs_ff, rtt_dq_ff, pre_ff; // registered outputs
   logic [7:0] dq_ff; // data output
   logic oe_b_ff; // output enable, low active
   wlmpr_pkg::rd_state_type st_ff; // readout state
   logic [RL_W-1:0] lat_ff; // latency counter
   logic [2:0] beat_ff, last_ff; // current and final beat
   logic [7:0] pat_ff; // selected readout location
   logic strobe_rise; // strobe rising edge
   wlmpr_if lnk ();

   // pin synchronisers; stage 0 only feeds stage 1
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         dqs_sync_ff <= 3'h0;
         ck_sync_ff <= 3'h0;
         odt_sync_ff <= 3'h0;
      end
      else
      begin
         dqs_sync_ff <= {dqs_sync_ff[1:0], dqs_i};
         ck_sync_ff <= {ck_sync_ff[1:0], ck_i};
         odt_sync_ff <= {odt_sync_ff[1:0], odt_i};
      end
   end
   // edge taken on stages 1 and 2, never on the first stage
   assign strobe_rise = dqs_sync_ff[1] & ~dqs_sync_ff[2];

   // mode register images
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         mr0_ff <= `MR_ADDR_RESET;
         mr1_ff <= `MR_ADDR_RESET;
         mr3_ff <= `MR_ADDR_RESET;
      end
      else if (mrs_i)
      begin
         case (mr_sel_i)
            3'h0: mr0_ff <= addr_i;
            3'h1:
            begin
               if (mr1_ff[`MR1_LEVEL_BIT] && addr_i[`MR1_LEVEL_BIT])
                  // while leveling only the output-off bit may change
                  mr1_ff[`MR1_QOFF_BIT] <= addr_i[`MR1_QOFF_BIT];
               else if (mr1_ff[`MR1_LEVEL_BIT])
                  // exit write takes the listed bits; the enable always drops, else we never leave
                  mr1_ff <= (mr1_ff & ~(`MR1_UPD_MASK | (16'h0001 << `MR1_LEVEL_BIT))) |
                            (addr_i & `MR1_UPD_MASK);
               else
                  mr1_ff <= addr_i;
            end
            3'h3: mr3_ff <= addr_i;
            default: ;
         endcase
      end
   end

   // termination: in leveling ODT only drives the strobe pair
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         rtt_dqs_ff <= 1'b0;
         rtt_dq_ff <= 1'b0;
      end
      else if (mr1_ff[`MR1_LEVEL_BIT])
      begin
         rtt_dqs_ff <= odt_sync_ff[1];
         rtt_dq_ff <= 1'b0;
      end
      else
      begin
         rtt_dqs_ff <= odt_sync_ff[1];
         rtt_dq_ff <= odt_sync_ff[1];
      end
   end

   // leveling link to the feedback stage
   assign lnk.level_en = mr1_ff[`MR1_LEVEL_BIT];
   assign lnk.sample_stb = strobe_rise & mr1_ff[`MR1_LEVEL_BIT];
   assign lnk.ck_level = ck_sync_ff[1];
   assign lnk.all_bits = fb_all_bits_i;

   wl_feedback fb_u (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .lnk(lnk)
   );

   // readout sequencer: latency wait then one beat per cycle
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         st_ff <= wlmpr_pkg::RD_IDLE;
         lat_ff <= '0;
         beat_ff <= 3'h0;
         last_ff <= 3'h0;
         pat_ff <= 8'h00;
      end
      else
      begin
         case (st_ff)
            wlmpr_pkg::RD_IDLE:
            begin
               if ((rd_i || rd_ap_i) && mr3_ff[`MR3_MPR_BIT])
               begin
                  st_ff <= wlmpr_pkg::RD_WAIT;
                  lat_ff <= rl_i;
                  // location 00 holds the calibration pattern; others reserved, read zero
                  pat_ff <= (mr3_ff[`MR3_LOC_LSB +: 2] == 2'h0) ? `MPR_PATTERN : 8'h00;
                  // chop on the fly only when MR0 burst field allows it; bank, A10 ignored
                  if (mr0_ff[`MR0_BL_LSB +: 2] == 2'h2 ||
                      (mr0_ff[`MR0_BL_LSB +: 2] == 2'h1 && !addr_i[`COL_BC_BIT]))
                  begin
                     beat_ff <= {addr_i[`COL_NIBBLE_BIT], 2'h0};
                     last_ff <= {addr_i[`COL_NIBBLE_BIT], 2'h3};
                  end
                  else
                  begin
                     beat_ff <= 3'h0;
                     last_ff <= 3'h7;
                  end
               end
            end
            wlmpr_pkg::RD_WAIT:
            begin
               if (lat_ff <= 1)
                  st_ff <= wlmpr_pkg::RD_BURST;
               else
                  lat_ff <= lat_ff - 1'b1;
            end
            wlmpr_pkg::RD_BURST:
            begin
               if (beat_ff == last_ff)
                  st_ff <= wlmpr_pkg::RD_IDLE;
               else
                  beat_ff <= beat_ff + 3'h1;
            end
            default: st_ff <= wlmpr_pkg::RD_IDLE;
         endcase
      end
   end

   // data pins: readout beats, else leveling feedback
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         dq_ff <= 8'h00;
         oe_b_ff <= 1'b1;
      end
      else if (st_ff == wlmpr_pkg::RD_BURST)
      begin
         // beat position picks the bit, position zero is the LSB
         dq_ff <= mpr_copy_i ? {8{pat_ff[beat_ff]}} : {7'h00, pat_ff[beat_ff]};
         oe_b_ff <= 1'b0;
      end
      else if (mr1_ff[`MR1_LEVEL_BIT] && lnk.fb_valid)
      begin
         dq_ff <= lnk.fb_dq;
         oe_b_ff <= 1'b0;
      end
      else
      begin
         dq_ff <= 8'h00;
         oe_b_ff <= 1'b1;
      end
   end

   // autoprecharge passes to the array only outside readout mode
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
         pre_ff <= 1'b0;
      else
         pre_ff <= rd_ap_i & ~mr3_ff[`MR3_MPR_BIT];
   end

   assign dq_o = dq_ff;
   assign dq_oe_b_o = oe_b_ff;
   assign rtt_dqs_o = rtt_dqs_ff;
   assign rtt_dq_o = rtt_dq_ff;
   assign level_mode_o = mr1_ff[`MR1_LEVEL_BIT];
   assign mpr_mode_o = mr3_ff[`MR3_MPR_BIT];
   assign mr1_o = mr1_ff;
   assign precharge_o = pre_ff;

   a_lvl_enter: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mrs_i && mr_sel_i == 3'h1 |=> level_mode_o == $past(addr_i[`MR1_LEVEL_BIT]))
      else $error("leveling mode does not follow MR1 write");
   a_dq_term_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      level_mode_o && $past(level_mode_o) |-> !rtt_dq_o)
      else $error("data termination on during leveling");
   a_no_ap_mpr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      rd_ap_i && mpr_mode_o |=> !precharge_o)
      else $error("precharge in readout mode");
   a_mpr_bit0: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      st_ff == wlmpr_pkg::RD_BURST |=> !dq_oe_b_o && dq_o[0] == $past(pat_ff[beat_ff]))
      else $error("readout bit order wrong");
   a_mpr_upper: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      st_ff == wlmpr_pkg::RD_BURST && !mpr_copy_i |=> dq_o[7:1] == 7'h00)
      else $error("upper bits not zero");
   a_mpr_pattern: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      st_ff == wlmpr_pkg::RD_IDLE && rd_i && mpr_mode_o && mr3_ff[1:0] == 2'h0
      |=> pat_ff == 8'haa)
      else $error("calibration pattern wrong");
   a_chop_nibble: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      st_ff == wlmpr_pkg::RD_IDLE && rd_i && mpr_mode_o && mr0_ff[1:0] == 2'h2
      |=> beat_ff == {$past(addr_i[2]), 2'h0} && last_ff == {$past(addr_i[2]), 2'h3})
      else $error("chopped nibble wrong");
   a_no_mpr_array: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      st_ff == wlmpr_pkg::RD_IDLE && rd_i && !mpr_mode_o |=> st_ff == wlmpr_pkg::RD_IDLE)
      else $error("array read started readout");
endmodule : wlmpr_top
`default_nettype wire

// ---- lvl_ctrl_model.sv ----
// Purpose: controller side model driving strobe, clock level and termination request
// Assumes: other ranks already have their output buffers off
// Notes: strobe stands low between pulses, it never runs free
`timescale 1ns/1ps
`default_nettype none
module lvl_ctrl_model (
   // clock
   input wire logic mclk_i,
   // pins toward the device
   output logic dqs_o,
   output logic ck_o,
   output logic odt_o
);
   // idle levels: strobe parked low, no termination request
   initial
   begin
      dqs_o = 1'b0;
      ck_o = 1'b0;
      odt_o = 1'b0;
   end
   // termination request, raised after the mode settles, dropped before exit
   task automatic set_odt(input logic on);
      @(posedge mclk_i);
      #1 odt_o = on;
      repeat (4) @(posedge mclk_i);
   endtask : set_odt
   // one rising strobe edge; clock level flips afterwards so a stale sample shows
   task automatic pulse(input logic lvl);
      @(posedge mclk_i);
      #1 ck_o = lvl;
      repeat (3) @(posedge mclk_i);
      #1 dqs_o = 1'b1;
      repeat (3) @(posedge mclk_i);
      #1 dqs_o = 1'b0;
      ck_o = ~lvl;
      repeat (5) @(posedge mclk_i);
      // hand back away from the clock edge so the bench samples settled pins
      @(negedge mclk_i);
   endtask : pulse
endmodule : lvl_ctrl_model
`default_nettype wire

// ---- tb_ddr3_write_leveling_and_mpr_readout.sv ----
// Purpose: self-checking bench for leveling feedback and register readout
// Assumes: read latency starts at two cycles; the readout test changes it to four and then one
// Notes: outputs are sampled on the falling edge except the array precharge check, taken 1 ns after rise; inputs move 1 ns after rise
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_ddr3_write_leveling_and_mpr_readout;
   logic mclk_i = 1'b0; // 200 MHz
   logic rst_b_i; // all inputs start in the main sequence
   logic mrs_i;
   logic [2:0] mr_sel_i;
   logic [15:0] addr_i;
   logic rd_i;
   logic rd_ap_i;
   logic fb_all_bits_i;
   logic mpr_copy_i;
   logic [4:0] rl; // read latency, varied by the readout test
   logic dqs, ck, odt; // from the controller model
   logic [7:0] dq_o;
   logic dq_oe_b_o, rtt_dqs_o, rtt_dq_o, level_mode_o, mpr_mode_o, precharge_o;
   logic [15:0] mr1_o;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   always #2.5 mclk_i = ~mclk_i;
   lvl_ctrl_model ctl (.mclk_i(mclk_i), .dqs_o(dqs), .ck_o(ck), .odt_o(odt));
   wlmpr_top DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .mrs_i(mrs_i), .mr_sel_i(mr_sel_i),
      .addr_i(addr_i), .rd_i(rd_i), .rd_ap_i(rd_ap_i), .odt_i(odt), .dqs_i(dqs), .ck_i(ck),
      .rl_i(rl), .fb_all_bits_i(fb_all_bits_i), .mpr_copy_i(mpr_copy_i), .dq_o(dq_o),
      .dq_oe_b_o(dq_oe_b_o), .rtt_dqs_o(rtt_dqs_o), .rtt_dq_o(rtt_dq_o),
      .level_mode_o(level_mode_o), .mpr_mode_o(mpr_mode_o), .mr1_o(mr1_o),
      .precharge_o(precharge_o));
   // verdict in one place
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         give_verdict();
      end
   end
   // one mode register write, then settle
   task automatic mrs(input logic [2:0] sel, input logic [15:0] a);
      @(posedge mclk_i);
      #1 mrs_i = 1'b1;
      mr_sel_i = sel;
      addr_i = a;
      @(posedge mclk_i);
      #1 mrs_i = 1'b0;
      @(posedge mclk_i);
      @(negedge mclk_i);
   endtask : mrs
   // one register read; n beats expected from pattern bits starting at s
   task automatic mpr_rd(input logic [15:0] a, input logic ap, input int n, input int s,
      input logic [7:0] pat);
      int i;
      logic b;
      @(posedge mclk_i);
      #1 rd_i = 1'b1;
      rd_ap_i = ap;
      addr_i = a;
      @(posedge mclk_i);
      #1 rd_i = 1'b0;
      rd_ap_i = 1'b0;
      @(negedge mclk_i);
      // autoprecharge would show in the cycle right after the command edge
      `CHK("precharge now", 1'b0, precharge_o)
      i = 0;
      while (dq_oe_b_o !== 1'b0 && i < 20)
      begin
         @(negedge mclk_i);
         i++;
      end
      `CHK("latency", int'(rl) + 1, i)
      for (i = 0; i < n; i++)
      begin
         b = pat[s + i];
         `CHK("beat", mpr_copy_i ? {8{b}} : {7'h00, b}, dq_o)
         `CHK("beat oe", 1'b0, dq_oe_b_o)
         `CHK("precharge", 1'b0, precharge_o)
         @(negedge mclk_i);
      end
      `CHK("burst end", 1'b1, dq_oe_b_o)
   endtask : mpr_rd
   // entry, termination, feedback on prime bit and all bits
   task automatic t_level();
      mrs(3'h1, 16'h0080);
      `CHK("level on", 1'b1, level_mode_o)
      `CHK("rtt off", 2'b00, {rtt_dqs_o, rtt_dq_o})
      ctl.set_odt(1'b1);
      @(negedge mclk_i);
      `CHK("rtt lvl", 2'b10, {rtt_dqs_o, rtt_dq_o})
      ctl.pulse(1'b0);
      `CHK("fb low", 9'h000, {dq_oe_b_o, dq_o})
      ctl.pulse(1'b1);
      `CHK("fb prime", 9'h001, {dq_oe_b_o, dq_o})
      @(posedge mclk_i);
      #1 fb_all_bits_i = 1'b1;
      ctl.pulse(1'b1);
      `CHK("fb all", 8'hff, dq_o)
      ctl.pulse(1'b0);
      `CHK("fb all low", 8'h00, dq_o)
      $display("test level done");
   endtask : t_level
   // output buffer toggle during leveling, then exit with masked update
   task automatic t_exit();
      mrs(3'h1, 16'h1080);
      `CHK("qoff on", 16'h1080, mr1_o)
      mrs(3'h1, 16'h0ae6);
      `CHK("only qoff", 16'h0080, mr1_o)
      ctl.set_odt(1'b0);
      mrs(3'h1, 16'hff7f);
      `CHK("exit image", 16'h1a66, mr1_o)
      `CHK("level off", 1'b0, level_mode_o)
      `CHK("fb released", 1'b1, dq_oe_b_o)
      ctl.set_odt(1'b1);
      @(negedge mclk_i);
      `CHK("rtt normal", 2'b11, {rtt_dqs_o, rtt_dq_o})
      ctl.set_odt(1'b0);
      $display("test exit done");
   endtask : t_exit
   // readout: full bursts, chops by nibble, reserved places, mode off
   task automatic t_mpr();
      int loc;
      mrs(3'h0, 16'h0000);
      mrs(3'h3, 16'h0004);
      `CHK("mpr on", 1'b1, mpr_mode_o)
      mpr_rd(16'h0000, 1'b0, 8, 0, 8'haa);
      @(posedge mclk_i);
      #1 mpr_copy_i = 1'b1;
      rl = 5'h04;
      mpr_rd(16'hfff8, 1'b1, 8, 0, 8'haa);
      mrs(3'h0, 16'h0001);
      mpr_rd(16'h0004, 1'b0, 4, 4, 8'haa);
      @(posedge mclk_i);
      #1 rl = 5'h01;
      mpr_rd(16'h0000, 1'b1, 4, 0, 8'haa);
      mpr_rd(16'h1000, 1'b0, 8, 0, 8'haa);
      mrs(3'h0, 16'h0002);
      mpr_rd(16'h1004, 1'b0, 4, 4, 8'haa);
      for (loc = 1; loc < 4; loc++)
      begin
         mrs(3'h3, 16'h0004 | 16'(loc));
         mpr_rd(16'h0000, 1'b0, 4, 0, 8'h00);
      end
      // readout recovery time before the mode is switched off
      repeat (4) @(posedge mclk_i);
      mrs(3'h3, 16'h0000);
      `CHK("mpr off", 1'b0, mpr_mode_o)
      @(posedge mclk_i);
      #1 rd_i = 1'b1;
      rd_ap_i = 1'b1;
      @(posedge mclk_i);
      #1 rd_i = 1'b0;
      rd_ap_i = 1'b0;
      `CHK("array precharge", 1'b1, precharge_o)
      repeat (12) @(negedge mclk_i);
      `CHK("array read", 1'b1, dq_oe_b_o)
      $display("test mpr done");
   endtask : t_mpr
   // main sequence
   initial
   begin
      rst_b_i = 1'b0;
      mrs_i = 1'b0;
      mr_sel_i = 3'h0;
      addr_i = 16'h0000;
      rd_i = 1'b0;
      rd_ap_i = 1'b0;
      fb_all_bits_i = 1'b0;
      mpr_copy_i = 1'b0;
      rl = 5'h02;
      repeat (5) @(posedge mclk_i);
      #1 rst_b_i = 1'b1;
      @(negedge mclk_i);
      `CHK("rst dq", 9'h100, {dq_oe_b_o, dq_o})
      `CHK("rst mr1", 16'h0000, mr1_o)
      `CHK("rst modes", 2'b00, {level_mode_o, mpr_mode_o})
      t_level();
      t_exit();
      t_mpr();
      give_verdict();
   end
endmodule : tb_ddr3_write_leveling_and_mpr_readout
`default_nettype wire
